// *** hw/rsc_top.sv ***
// reference monitor, switchover control, holdover and output dividers
// Summary of operation
// - each reference is watched for presence all the time by hardware alone.
// - if only one reference is present it becomes the active one; in manual mode, only if it is the chosen one.
// - if both are present one is active and the other waits as backup.
// - in automatic mode, when the active reference fails the present backup takes over; manual mode enters holdover.
// - a control bit picks whether a returning primary is taken back or not.
// - with no reference present the block enters holdover on the oscillator.
// - a dedicated pin can choose the active reference.
// - each output divider divides by an integer from 1 to 1024.
// - all divider settings are written over the control port by the host.
// - each output divider adds a programmable start delay.
// - presence is judged on the prescaled reference, not the raw input.
// - each reference prescaler divides by an integer from 1 to 1023.
// - non-reverting mode stays on secondary but falls back if it vanishes.
// - holdover floats the first-loop charge pump and ends when a reference returns (in manual mode, the chosen one).
`include "rsc_cfg.svh"
module rsc_top
    import rsc_pkg::*;
#(
    parameter int N_OUT    = 14,
    parameter int MON_CYC  = `RSC_LOSS_CYC
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        primary_reference_input,
    input  wire logic        secondary_reference_input,
    input  wire logic        ref_select_pin,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic             active_is_secondary,
    output logic             holdover,
    output logic             charge_pump_tristate,
    output logic [N_OUT-1:0] clk_out,
    output logic             irq
);
    localparam int MON_W = $clog2(MON_CYC + 1);
    localparam logic [MON_W-1:0] MON_MAX = MON_W'(MON_CYC);

    typedef struct packed {
        logic [1:0]             ref_prev;
        logic [1:0][9:0]        pre_cnt;
        logic [1:0][MON_W-1:0]  mon_cnt;
        logic [1:0]             pres_d;
        rsc_sel_t               sel;
        logic [3:0]             ctrl;
        logic [1:0][9:0]        pre_ratio;
        logic [N_OUT-1:0][9:0]  div_m1;
        logic [N_OUT-1:0][5:0]  div_dly;
        logic                   sync;
        logic [3:0]             irq_stat;
        logic [3:0]             irq_mask;
        logic [31:0]            rdata;
    } rsc_st_t;

    rsc_st_t    st_reg;
    rsc_st_t    st_next;
    logic [1:0] ref_in;
    logic [1:0] tick;
    logic [1:0] pres;
    logic       want_b;
    logic       manual;
    logic [3:0] events;
    logic [7:0] div_idx;

    assign ref_in = {secondary_reference_input, primary_reference_input};

    // ----------------------------------------
    // prescalers, monitors, switchover, registers
    // ----------------------------------------
    always_comb
    begin
        st_next = st_reg;
        tick    = 2'b00;
        pres    = 2'b00;
        div_idx = addr - `RSC_OFF_DIV_BASE;
        for (int i = 0; i < 2; i++)
        begin
            st_next.ref_prev[i] = ref_in[i];
            if (ref_in[i] && !st_reg.ref_prev[i])
            begin
                if (st_reg.pre_cnt[i] + 10'h001 >= st_reg.pre_ratio[i])
                begin
                    st_next.pre_cnt[i] = 10'h000;
                    tick[i]            = 1'b1;
                end
                else
                    st_next.pre_cnt[i] = st_reg.pre_cnt[i] + 10'h001;
            end
            if (tick[i])
                st_next.mon_cnt[i] = '0;
            else if (st_reg.mon_cnt[i] < MON_MAX)
                st_next.mon_cnt[i] = st_reg.mon_cnt[i] + 1'b1;
            pres[i]            = (st_reg.mon_cnt[i] < MON_MAX);
            st_next.pres_d[i]  = pres[i];
        end

        // pin or bit picks the target
        manual = st_reg.ctrl[`RSC_CTRL_MANUAL];
        want_b = st_reg.ctrl[`RSC_CTRL_USE_PIN] ? ref_select_pin : st_reg.ctrl[`RSC_CTRL_SEL_B];

        if (manual)
        begin
            if (want_b && pres[1])
                st_next.sel = RSC_ON_B;
            else if (!want_b && pres[0])
                st_next.sel = RSC_ON_A;
            else
                st_next.sel = RSC_HOLD;
        end
        else
        begin
            case (st_reg.sel)
                RSC_ON_A:
                begin
                    if (!pres[0])
                        st_next.sel = pres[1] ? RSC_ON_B : RSC_HOLD;
                end
                RSC_ON_B:
                begin
                    if (!pres[1])
                        st_next.sel = pres[0] ? RSC_ON_A : RSC_HOLD;
                    else if (st_reg.ctrl[`RSC_CTRL_REVERT] && pres[0])
                        st_next.sel = RSC_ON_A;
                end
                default:
                begin
                    if (pres[0])
                        st_next.sel = RSC_ON_A;
                    else if (pres[1])
                        st_next.sel = RSC_ON_B;
                    else
                        st_next.sel = RSC_HOLD;
                end
            endcase
        end

        // event sources for the interrupt status
        events                     = 4'h0;
        events[`RSC_IRQ_SWITCH]    = (st_next.sel != st_reg.sel);
        events[`RSC_IRQ_HOLD]      = (st_next.sel == RSC_HOLD) && (st_reg.sel != RSC_HOLD);
        events[`RSC_IRQ_A_LOST]    = st_reg.pres_d[0] && !pres[0];
        events[`RSC_IRQ_B_LOST]    = st_reg.pres_d[1] && !pres[1];

        // read data valid only in the cycle after the strobe
        st_next.rdata = 32'h0000_0000;
        st_next.sync  = 1'b0;
        if (rd)
        begin
            if (addr == `RSC_OFF_CTRL)
                st_next.rdata = {28'h0, st_reg.ctrl};
            else if (addr == `RSC_OFF_STATUS)
                st_next.rdata = {28'h0, st_reg.sel == RSC_HOLD, st_reg.sel == RSC_ON_B, pres};
            else if (addr == `RSC_OFF_IRQ_STAT)
                st_next.rdata = {28'h0, st_reg.irq_stat};
            else if (addr == `RSC_OFF_IRQ_MASK)
                st_next.rdata = {28'h0, st_reg.irq_mask};
            else if (addr == `RSC_OFF_PRE_A)
                st_next.rdata = {22'h0, st_reg.pre_ratio[0]};
            else if (addr == `RSC_OFF_PRE_B)
                st_next.rdata = {22'h0, st_reg.pre_ratio[1]};
            else if (addr >= `RSC_OFF_DIV_BASE && div_idx < 8'(N_OUT))
                st_next.rdata = {10'h0, st_reg.div_dly[div_idx], 6'h0, st_reg.div_m1[div_idx]};
        end
        if (wr)
        begin
            if (addr == `RSC_OFF_CTRL)
                st_next.ctrl = wdata[3:0];
            else if (addr == `RSC_OFF_IRQ_MASK)
                st_next.irq_mask = wdata[3:0];
            else if (addr == `RSC_OFF_PRE_A)
                st_next.pre_ratio[0] = wdata[9:0];
            else if (addr == `RSC_OFF_PRE_B)
                st_next.pre_ratio[1] = wdata[9:0];
            else if (addr == `RSC_OFF_SYNC)
                st_next.sync = 1'b1;
            else if (addr >= `RSC_OFF_DIV_BASE && div_idx < 8'(N_OUT))
            begin
                st_next.div_m1[div_idx]  = wdata[9:0];
                st_next.div_dly[div_idx] = wdata[`RSC_DIV_DLY_LSB +: 6];
            end
        end
        // clear on read, but a same-cycle event still lands
        st_next.irq_stat = ((rd && addr == `RSC_OFF_IRQ_STAT) ? 4'h0 : st_reg.irq_stat) | events;
    end

    // single register for all state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg           <= '0;
            st_reg.sel       <= RSC_HOLD;
            st_reg.ctrl      <= `RSC_CTRL_RST;
            st_reg.irq_mask  <= `RSC_MASK_RST;
            st_reg.pre_ratio <= {2{`RSC_PRE_RST}};
            st_reg.div_m1    <= {N_OUT{`RSC_DIV_RST}};
            st_reg.div_dly   <= {N_OUT{`RSC_DLY_RST}};
            st_reg.mon_cnt   <= {2{MON_MAX}};
        end
        else
            st_reg <= st_next;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdata               = st_reg.rdata;
    assign active_is_secondary = (st_reg.sel == RSC_ON_B);
    assign holdover            = (st_reg.sel == RSC_HOLD);
    assign charge_pump_tristate = (st_reg.sel == RSC_HOLD);
    assign irq                 = |(st_reg.irq_stat & st_reg.irq_mask);

    // one divider per output, all restarted together by the sync write
    for (genvar g = 0; g < N_OUT; g++)
    begin : g_div
        rsc_out_div #(
            .DIV_W (10),
            .DLY_W (6)
        ) rsc_out_div_inst (
            .clk      (clk),
            .rst      (rst),
            .sync     (st_reg.sync),
            .ratio_m1 (st_reg.div_m1[g]),
            .delay    (st_reg.div_dly[g]),
            .clk_out  (clk_out[g])
        );
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_FAILOVER: assert property (@(posedge clk) disable iff (rst)
        (!manual && st_reg.sel == RSC_ON_A && !pres[0] && pres[1]) |=> active_is_secondary)
        else $error("no failover to secondary");
    AST_HOLD_ENTER: assert property (@(posedge clk) disable iff (rst)
        (pres == 2'b00) |=> holdover && charge_pump_tristate)
        else $error("holdover not entered");
    AST_REVERT: assert property (@(posedge clk) disable iff (rst)
        (!manual && st_reg.sel == RSC_ON_B && st_reg.ctrl[`RSC_CTRL_REVERT] && pres == 2'b11)
        |=> st_reg.sel == RSC_ON_A)
        else $error("no revert to primary");
    AST_STAY: assert property (@(posedge clk) disable iff (rst)
        (!manual && st_reg.sel == RSC_ON_B && !st_reg.ctrl[`RSC_CTRL_REVERT] && pres[1])
        |=> active_is_secondary)
        else $error("left secondary in non-reverting mode");
    AST_FALLBACK: assert property (@(posedge clk) disable iff (rst)
        (!manual && st_reg.sel == RSC_ON_B && !pres[1] && pres[0]) |=> st_reg.sel == RSC_ON_A)
        else $error("no fallback to primary");
    AST_SINGLE: assert property (@(posedge clk) disable iff (rst)
        (!manual && st_reg.sel == RSC_HOLD && pres == 2'b10) |=> active_is_secondary)
        else $error("lone secondary not taken");
    AST_MANUAL: assert property (@(posedge clk) disable iff (rst)
        (manual && want_b && pres[1]) |=> active_is_secondary)
        else $error("manual choice ignored");
    AST_PRESENT: assert property (@(posedge clk) disable iff (rst)
        tick[0] |=> ##1 pres[0])
        else $error("prescaled edge not seen as presence");
    AST_IRQ: assert property (@(posedge clk) disable iff (rst)
        (events[`RSC_IRQ_HOLD] && st_reg.irq_mask[`RSC_IRQ_HOLD]) |=> irq [*2])
        else $error("holdover interrupt lost");
    // auto mode must drop holdover as soon as either reference is back
    AST_RESYNC: assert property (@(posedge clk) disable iff (rst)
        (!manual && st_reg.sel == RSC_HOLD && pres != 2'b00) |=> !holdover && !charge_pump_tristate)
        else $error("holdover kept with a reference back");
    AST_BOTH_ACTIVE: assert property (@(posedge clk) disable iff (rst)
        (!manual && st_reg.sel != RSC_HOLD && pres == 2'b11) |=> !holdover)
        else $error("no active reference with both present");
    // ratio zero or one gives a tick on every edge
    AST_PRESCALE_ONE: assert property (@(posedge clk) disable iff (rst)
        (ref_in[0] && !st_reg.ref_prev[0] && st_reg.pre_ratio[0] <= 10'h001) |-> tick[0])
        else $error("unit prescaler dropped an edge");
    // read data must not linger past their one cycle
    AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (rst)
        !rd |=> rdata == 32'h0000_0000)
        else $error("read data stood without a read");

    COV_FAILOVER: cover property (@(posedge clk) disable iff (rst)
        st_reg.sel == RSC_ON_A ##1 st_reg.sel == RSC_ON_B);
    COV_HOLD: cover property (@(posedge clk) disable iff (rst)
        st_reg.sel != RSC_HOLD ##1 holdover);
    COV_REVERT: cover property (@(posedge clk) disable iff (rst)
        st_reg.sel == RSC_ON_B ##1 st_reg.sel == RSC_ON_A);
    // manual change of choice while both are present
    COV_MANUAL: cover property (@(posedge clk) disable iff (rst)
        manual && st_reg.sel == RSC_ON_A ##1 active_is_secondary);
endmodule

// *** hw/rsc_cfg.svh ***
// register offsets, field positions, reset values and timing counts of the switchover block
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
// ----------------------------------------
// register offsets (word index on the plain port)
// ----------------------------------------
`define RSC_OFF_CTRL      8'h00
`define RSC_OFF_STATUS    8'h01
`define RSC_OFF_IRQ_STAT  8'h02
`define RSC_OFF_IRQ_MASK  8'h03
`define RSC_OFF_PRE_A     8'h04
`define RSC_OFF_PRE_B     8'h05
`define RSC_OFF_SYNC      8'h06
`define RSC_OFF_DIV_BASE  8'h10
// ----------------------------------------
// field positions
// ----------------------------------------
`define RSC_CTRL_MANUAL   0
`define RSC_CTRL_USE_PIN  1
`define RSC_CTRL_SEL_B    2
`define RSC_CTRL_REVERT   3
`define RSC_DIV_DLY_LSB   16
`define RSC_IRQ_SWITCH    0
`define RSC_IRQ_HOLD      1
`define RSC_IRQ_A_LOST    2
`define RSC_IRQ_B_LOST    3
// ----------------------------------------
// reset values
// ----------------------------------------
`define RSC_CTRL_RST      4'h0
`define RSC_PRE_RST       10'h001
`define RSC_DIV_RST       10'h000
`define RSC_DLY_RST       6'h00
`define RSC_MASK_RST      4'h0
// ----------------------------------------
// timing
// ----------------------------------------
`define RSC_CLK_PERIOD_NS 5
`define RSC_LOSS_NS       20480
`define RSC_LOSS_CYC      (`RSC_LOSS_NS / `RSC_CLK_PERIOD_NS)
`endif

// *** hw/rsc_pkg.sv ***
// types shared by the switchover block
package rsc_pkg;
    typedef enum logic [1:0]
    {
        RSC_HOLD = 2'b00,
        RSC_ON_A = 2'b01,
        RSC_ON_B = 2'b10
    } rsc_sel_t;
endpackage

// *** hw/rsc_out_div.sv ***
// one output divider with integer ratio and start delay
module rsc_out_div
    import rsc_pkg::*;
#(
    parameter int DIV_W = 10,
    parameter int DLY_W = 6
)(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             sync,
    input  wire logic [DIV_W-1:0] ratio_m1,
    input  wire logic [DLY_W-1:0] delay,
    output logic                  clk_out
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic [DLY_W-1:0] dly;
        logic             out;
    } rsc_div_st_t;

    rsc_div_st_t st_reg;
    rsc_div_st_t st_next;
    logic [DIV_W:0] half;

    // high for the first ceil(ratio/2) cycles of each period
    always_comb
    begin
        st_next = st_reg;
        half    = ({1'b0, ratio_m1} + {{DIV_W{1'b0}}, 1'b1} + {{DIV_W{1'b0}}, 1'b1}) >> 1;
        if (sync)
        begin
            st_next.cnt = '0;
            st_next.dly = delay;
            st_next.out = 1'b0;
        end
        else if (st_reg.dly != '0)
        begin
            st_next.dly = st_reg.dly - 1'b1;
            st_next.out = 1'b0;
        end
        else
        begin
            if (st_reg.cnt >= ratio_m1)
                st_next.cnt = '0;
            else
                st_next.cnt = st_reg.cnt + 1'b1;
            st_next.out = ({1'b0, st_next.cnt} < half);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign clk_out = st_reg.out;

    AST_DELAY_LOW: assert property (@(posedge clk) disable iff (rst)
        (sync && delay > 1) |=> !clk_out [*2])
        else $error("delayed divider output went high early");
endmodule

// *** verif/rsc_ref_src.sv ***
// model of the two external reference clock sources
module rsc_ref_src
(
    input  wire logic       clk,
    input  wire logic       en_a,
    input  wire logic       en_b,
    input  wire logic [3:0] half_a,
    input  wire logic [3:0] half_b,
    output logic            ref_a,
    output logic            ref_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_a;
    logic [3:0] cnt_b;
    // ----------------------------------------
    // square waves, still while disabled
    // ----------------------------------------
    // a failed source stops toggling; half period of at least 2 keeps it below clk/2
    always @(posedge clk)
    begin
        cnt_a <= (!en_a || cnt_a == half_a - 4'h1) ? 4'h0 : cnt_a + 4'h1;
        cnt_b <= (!en_b || cnt_b == half_b - 4'h1) ? 4'h0 : cnt_b + 4'h1;
        if (!en_a)
            ref_a <= 1'b0;
        else if (cnt_a == half_a - 4'h1)
            ref_a <= ~ref_a;
        if (!en_b)
            ref_b <= 1'b0;
        else if (cnt_b == half_b - 4'h1)
            ref_b <= ~ref_b;
    end
endmodule

// *** verif/reference_switchover_control_test.sv ***
// self-checking bench for the reference switchover block
`include "rsc_cfg.svh"
module reference_switchover_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MON = 16;
    logic        clk, rst, ref_a, ref_b, sel_pin, wr, rd, en_a, en_b;
    logic        ais, hold, cpt, irq;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, got;
    logic [13:0] cko;
    int          miscompares, n_checks, n, t0, t2;
    // ----------------------------------------
    // clock, design and partner
    // ----------------------------------------
    // free running 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    rsc_top #(.N_OUT(14), .MON_CYC(MON)) rsc_top_inst (.clk(clk), .rst(rst), .primary_reference_input(ref_a),
        .secondary_reference_input(ref_b), .ref_select_pin(sel_pin), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .active_is_secondary(ais), .holdover(hold), .charge_pump_tristate(cpt),
        .clk_out(cko), .irq(irq));
    rsc_ref_src rsc_ref_src_inst (.clk(clk), .en_a(en_a), .en_b(en_b), .half_a(4'h2), .half_b(4'h3),
        .ref_a(ref_a), .ref_b(ref_b));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one-cycle strobes, launched just after an edge
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        got = rdata;
        if (nm != "")
            chk(nm, exp, got);
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // bounded wait for {holdover, on secondary}; pump float follows holdover
    task automatic wait_sel(input logic [1:0] exp);
        // step off the edge so registered outputs have settled
        #1;
        for (n = 0; n < 4 * MON && {hold, ais} !== exp; n++)
            idle(1);
        chk("selection", {29'h0, exp[1], exp}, {29'h0, cpt, hold, ais});
        if ({hold, ais} !== exp)
            complete_run();
    endtask
    // one full period from a rising edge: length and high time
    task automatic div_chk(input int idx, input int ratio);
        logic p;
        int   hi;
        p  = 1'b1;
        hi = 0;
        for (n = 0; n < 2 * ratio + 80 && !(p === 1'b0 && cko[idx] === 1'b1); n++)
        begin
            p = cko[idx];
            idle(1);
        end
        if (n >= 2 * ratio + 80)
        begin
            chk("div edge", 32'h1, 32'h0);
            complete_run();
        end
        for (n = 0; n < ratio; n++)
        begin
            hi += (cko[idx] === 1'b1);
            p = cko[idx];
            idle(1);
        end
        chk("div high", 32'((ratio + 1) / 2), 32'(hi));
        chk("div period", 32'h1, {30'h0, p, cko[idx]});
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {rst, wr, rd, addr, wdata, sel_pin, en_a, en_b} = {1'b1, 45'h0};
        miscompares = 0;
        n_checks = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wait_sel(2'b10);
        rd_chk("ctrl", `RSC_OFF_CTRL, 32'h0);
        rd_chk("prescale", `RSC_OFF_PRE_A, 32'h1);
        reg_wr(8'h7F, 32'hFFFFFFFF);
        rd_chk("unmapped", 8'h7F, 32'h0);
        reg_wr(`RSC_OFF_IRQ_MASK, 32'hF);
        rd_chk("mask", `RSC_OFF_IRQ_MASK, 32'hF);
        en_a <= 1'b1;
        en_b <= 1'b1;
        wait_sel(2'b00);
        idle(8);
        rd_chk("status both", `RSC_OFF_STATUS, 32'h3);
        rd_chk("", `RSC_OFF_IRQ_STAT, 32'h0);
        idle(2);
        chk("irq idle", 32'h0, {31'h0, irq});
        en_a <= 1'b0;
        wait_sel(2'b01);
        idle(2);
        chk("irq set", 32'h1, {31'h0, irq});
        rd_chk("irq stat", `RSC_OFF_IRQ_STAT, 32'h5);
        idle(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        en_a <= 1'b1;
        idle(4 * MON);
        rd_chk("status stay", `RSC_OFF_STATUS, 32'h7);
        en_b <= 1'b0;
        wait_sel(2'b00);
        reg_wr(`RSC_OFF_CTRL, 32'h8);
        en_b <= 1'b1;
        idle(8);
        en_a <= 1'b0;
        wait_sel(2'b01);
        en_a <= 1'b1;
        wait_sel(2'b00);
        reg_wr(`RSC_OFF_PRE_A, 32'h3FF);
        idle(4 * MON);
        rd_chk("status slow", `RSC_OFF_STATUS, 32'h6);
        reg_wr(`RSC_OFF_PRE_A, 32'h3);
        wait_sel(2'b00);
        reg_wr(`RSC_OFF_PRE_A, 32'h3FF);
        rd_chk("prescale max", `RSC_OFF_PRE_A, 32'h3FF);
        reg_wr(`RSC_OFF_PRE_A, 32'h1);
        wait_sel(2'b00);
        rd_chk("", `RSC_OFF_IRQ_STAT, 32'h0);
        en_a <= 1'b0;
        en_b <= 1'b0;
        wait_sel(2'b10);
        rd_chk("", `RSC_OFF_IRQ_STAT, 32'h0);
        chk("hold event", 32'h1, {31'h0, got[1]});
        en_b <= 1'b1;
        wait_sel(2'b01);
        en_a <= 1'b1;
        reg_wr(`RSC_OFF_CTRL, 32'h3);
        wait_sel(2'b00);
        sel_pin <= 1'b1;
        wait_sel(2'b01);
        sel_pin <= 1'b0;
        wait_sel(2'b00);
        reg_wr(`RSC_OFF_CTRL, 32'h5);
        wait_sel(2'b01);
        en_b <= 1'b0;
        wait_sel(2'b10);
        reg_wr(`RSC_OFF_DIV_BASE, 32'h0003_0003);
        reg_wr(`RSC_OFF_DIV_BASE + 8'h2, 32'h0006_0003);
        reg_wr(`RSC_OFF_DIV_BASE + 8'h1, 32'h3FF);
        reg_wr(`RSC_OFF_DIV_BASE + 8'hD, 32'h0);
        rd_chk("div reg", `RSC_OFF_DIV_BASE + 8'h2, 32'h0006_0003);
        reg_wr(`RSC_OFF_SYNC, 32'h1);
        // first rises after restart; early samples may still show the old pattern
        t0 = -1;
        t2 = -1;
        idle(3);
        for (int k = 0; k < 40; k++)
        begin
            idle(1);
            if (t0 < 0 && cko[0] === 1'b1)
                t0 = k;
            if (t2 < 0 && cko[2] === 1'b1)
                t2 = k;
        end
        chk("delay", 32'h3, 32'(t2 - t0));
        div_chk(0, 4);
        div_chk(1, 1024);
        chk("ratio one", 32'h1, {31'h0, cko[13]});
        idle(3);
        chk("ratio one", 32'h1, {31'h0, cko[13]});
        complete_run();
    end
endmodule
